// >>> design/eepw_consts.svh
// Timing counts and fixed field positions of the serial EEPROM target.
`ifndef EEPW_CONSTS_SVH
`define EEPW_CONSTS_SVH

// ==========================================================================
// Clock periods in picoseconds
`define EEPW_CLK_PERIOD_PS        4000
`define EEPW_LINK_PERIOD_PS       12000

// ==========================================================================
// Times in their own units and derived cycle counts
`define EEPW_PROG_TIME_MS         5
// Divided first, so the product stays inside 32-bit integer arithmetic.
`define EEPW_PROG_CYCLES          (`EEPW_PROG_TIME_MS * (1000000000 / `EEPW_CLK_PERIOD_PS))
`define EEPW_GLITCH_NS            50
`define EEPW_GLITCH_CYCLES        ((`EEPW_GLITCH_NS * 1000 + `EEPW_LINK_PERIOD_PS - 1) / `EEPW_LINK_PERIOD_PS)
`define EEPW_POR_NS               1000
`define EEPW_POR_CYCLES           ((`EEPW_POR_NS * 1000 + `EEPW_LINK_PERIOD_PS - 1) / `EEPW_LINK_PERIOD_PS)

// ==========================================================================
// Array geometry and address word fields
`define EEPW_ADDR_W               13
`define EEPW_DEPTH                8192
`define EEPW_PAGE_BYTES           32
`define EEPW_OFS_W                5
`define EEPW_PAGE_W               8
`define EEPW_TIMER_W              21
`define EEPW_FILT_W               3
`define EEPW_POR_W                7
`define EEPW_BITS_PER_BYTE        4'h8

`endif

// >>> design/eepw_pkg.sv
// Types shared by the serial EEPROM target design.
package eepw_pkg;

  // ========================================================================
  // Bus line pair
  typedef struct packed {
    logic scl;
    logic sda;
  } eepw_line_t;

  // ========================================================================
  // Protocol engine states and received byte roles
  typedef enum {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_RACK
  } eepw_state_t;

  typedef enum logic [1:0] {
    KIND_DEV,
    KIND_AHI,
    KIND_ALO,
    KIND_DATA
  } eepw_kind_t;

endpackage : eepw_pkg

// >>> design/eepw_filter.sv
// Two-flop synchroniser and glitch filter for the bus lines.
`timescale 1ns/1ps
`include "eepw_consts.svh"

module eepw_filter (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire eepw_pkg::eepw_line_t i_line,
  output eepw_pkg::eepw_line_t   o_line
);

  // ========================================================================
  // Per-line synchroniser and stability counter
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_line
      logic                    sync1_reg;
      logic                    sync2_reg;
      logic                    out_reg;
      logic                    out_next;
      logic [`EEPW_FILT_W-1:0] cnt_reg;
      logic [`EEPW_FILT_W-1:0] cnt_next;

      // A change is taken only once it has held longer than the glitch width.
      always_comb begin
        out_next = out_reg;
        cnt_next = '0;
        if (sync2_reg != out_reg) begin
          if (cnt_reg == `EEPW_FILT_W'(`EEPW_GLITCH_CYCLES)) begin
            out_next = sync2_reg;
          end else begin
            cnt_next = cnt_reg + `EEPW_FILT_W'(1);
          end
        end
      end

      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sync1_reg <= 1'b1;
          sync2_reg <= 1'b1;
          out_reg   <= 1'b1;
          cnt_reg   <= '0;
        end else begin
          sync1_reg <= i_line[g];
          sync2_reg <= sync1_reg;
          out_reg   <= out_next;
          cnt_reg   <= cnt_next;
        end
      end

      assign o_line[g] = out_reg;
    end
  endgenerate

endmodule : eepw_filter

// >>> design/eepw_top.sv
// Serial two-wire EEPROM target: protocol engine, page buffer, array, write timer.
// What this block does
// - Take one to 32 data bytes per write and program them in one cycle.
// - A further data byte instead of a stop continues as a page write.
// - Each extra write byte advances only the five in-page offset bits.
// - Offset wraps inside the page; later bytes overwrite earlier buffered ones.
// - A stop after write data ends input and starts the timed program cycle.
// - While programming, address words get no acknowledge; afterwards they do.
// - Address counter holds last accessed address plus one for current reads.
// - Current read acknowledges address word then sends counter byte, MSB first.
// - Not-acknowledge then stop ends a read; device releases line, goes standby.
// - Read past last array address wraps the counter to zero.
// - Write ending at last page location wraps counter to same page start.
// - Counter resets to zero at power-up; controller does a random read first.
// - Dummy write loads two address bytes; repeated start read returns that data.
// - Each acknowledged read byte advances the address and sends the next byte.
// - Sequential read past the array end wraps to zero and continues.
// - Power-on guard keeps bus noise during start-up from starting a write.
// - Both bus inputs ignore pulses narrower than 50 ns.
// - Address word: type code, straps A2 A1 A0, direction; mismatch means standby.
// - Eight bits per byte; receiver drives acknowledge low on the ninth clock.
// - Program cycle ends within 5 ms of the stop; bus ignored meanwhile.
`timescale 1ns/1ps
`include "eepw_consts.svh"

module eepw_top #(
  parameter int unsigned         PROG_CYCLES      = `EEPW_PROG_CYCLES,
  parameter logic [3:0]          DEVICE_TYPE_CODE = 4'h5 // Arbitrary value.
) (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_link_clk,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda,
  output logic      o_sda_oe,
  input  wire logic i_chip_select_strap_bit0,
  input  wire logic i_chip_select_strap_bit1,
  input  wire logic i_chip_select_strap_bit2
);

  // ========================================================================
  // Reset release in both domains
  logic rst1_reg;
  logic rst_n;
  logic lrst1_reg;
  logic lrst_n;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst1_reg <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst1_reg <= 1'b1;
      rst_n    <= rst1_reg;
    end
  end

  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lrst1_reg <= 1'b0;
      lrst_n    <= 1'b0;
    end else begin
      lrst1_reg <= 1'b1;
      lrst_n    <= lrst1_reg;
    end
  end

  // ========================================================================
  // Input filtering and strap capture
  eepw_pkg::eepw_line_t pin_line;
  eepw_pkg::eepw_line_t flt_line;
  logic [2:0]           strap1_reg;
  logic [2:0]           strap_reg;

  assign pin_line.scl = i_scl;
  assign pin_line.sda = i_sda;

  eepw_filter u_filter (
    .i_clk   (i_link_clk),
    .i_rst_n (lrst_n),
    .i_line  (pin_line),
    .o_line  (flt_line)
  );

  always_ff @(posedge i_link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      strap1_reg <= '0;
      strap_reg  <= '0;
    end else begin
      strap1_reg <= {i_chip_select_strap_bit2, i_chip_select_strap_bit1,
                     i_chip_select_strap_bit0};
      strap_reg  <= strap1_reg;
    end
  end

  // ========================================================================
  // Protocol engine state
  eepw_pkg::eepw_state_t     st_reg, st_next;
  eepw_pkg::eepw_kind_t      kind_reg, kind_next;
  logic [3:0]                cnt_reg, cnt_next;
  logic [7:0]                sh_reg, sh_next;
  logic [`EEPW_ADDR_W-1:0]   addr_reg, addr_next;
  logic [`EEPW_PAGE_W-1:0]   wpage_reg, wpage_next;
  logic [`EEPW_PAGE_BYTES-1:0] valid_reg, valid_next;
  logic                      rw_reg, rw_next;
  logic                      oe_reg, oe_next;
  logic                      had_data_reg, had_data_next;
  logic                      busy_reg, busy_next;
  logic                      req_tgl_reg, req_tgl_next;
  logic                      scl_prev_reg;
  logic                      sda_prev_reg;
  logic [`EEPW_POR_W-1:0]    por_cnt_reg, por_cnt_next;
  logic                      por_ok_reg, por_ok_next;
  logic                      done1_reg, done2_reg, done3_reg;
  logic                      req1_reg, req2_reg, req3_reg;
  logic                      done_tgl_reg, done_tgl_next;
  logic                      run_reg, run_next;
  logic [`EEPW_TIMER_W-1:0]  tmr_reg, tmr_next;
  logic                      buf_we;
  logic [7:0]                mem [0:`EEPW_DEPTH-1];
  logic [7:0]                page_buf [0:`EEPW_PAGE_BYTES-1];
  logic                      scl_rise, scl_fall, start_cond, stop_cond, done_evt;

  assign scl_rise   = flt_line.scl & ~scl_prev_reg;
  assign scl_fall   = ~flt_line.scl & scl_prev_reg;
  assign start_cond = flt_line.scl & scl_prev_reg & sda_prev_reg & ~flt_line.sda;
  assign stop_cond  = flt_line.scl & scl_prev_reg & ~sda_prev_reg & flt_line.sda;
  assign done_evt   = done2_reg ^ done3_reg;

  always_comb begin
    st_next       = st_reg;
    kind_next     = kind_reg;
    cnt_next      = cnt_reg;
    sh_next       = sh_reg;
    addr_next     = addr_reg;
    wpage_next    = wpage_reg;
    valid_next    = valid_reg;
    rw_next       = rw_reg;
    oe_next       = oe_reg;
    had_data_next = had_data_reg;
    busy_next     = busy_reg;
    req_tgl_next  = req_tgl_reg;
    buf_we        = 1'b0;
    por_cnt_next  = por_cnt_reg;
    por_ok_next   = por_ok_reg;
    // Lines must idle high for a while after reset before any frame counts.
    if (!por_ok_reg) begin
      if (flt_line.scl && flt_line.sda) begin
        por_cnt_next = por_cnt_reg + `EEPW_POR_W'(1);
        if (por_cnt_reg == `EEPW_POR_W'(`EEPW_POR_CYCLES)) begin
          por_ok_next = 1'b1;
        end
      end else begin
        por_cnt_next = '0;
      end
    end
    if (done_evt) begin
      busy_next = 1'b0;
    end
    if (!por_ok_reg) begin
      st_next = eepw_pkg::ST_IDLE;
    end else if (stop_cond) begin
      st_next = eepw_pkg::ST_IDLE;
      oe_next = 1'b0;
      if (had_data_reg && !rw_reg && !busy_reg) begin
        busy_next    = 1'b1;
        req_tgl_next = ~req_tgl_reg;
      end
      had_data_next = 1'b0;
    end else if (start_cond) begin
      st_next       = eepw_pkg::ST_RX;
      kind_next     = eepw_pkg::KIND_DEV;
      cnt_next      = '0;
      oe_next       = 1'b0;
      had_data_next = 1'b0;
    end else begin
      case (st_reg)
        eepw_pkg::ST_RX: begin
          if (scl_rise) begin
            sh_next  = {sh_reg[6:0], flt_line.sda};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == `EEPW_BITS_PER_BYTE) begin
            st_next = eepw_pkg::ST_ACK;
            oe_next = 1'b1;
            case (kind_reg)
              eepw_pkg::KIND_DEV: begin
                rw_next = sh_reg[0];
                if (sh_reg[7:4] != DEVICE_TYPE_CODE || sh_reg[3:1] != strap_reg
                    || busy_reg) begin
                  st_next = eepw_pkg::ST_IDLE;
                  oe_next = 1'b0;
                end
              end
              eepw_pkg::KIND_AHI: begin
                addr_next[`EEPW_ADDR_W-1:8] = sh_reg[`EEPW_ADDR_W-9:0];
              end
              eepw_pkg::KIND_ALO: begin
                addr_next[7:0] = sh_reg;
                // The page takes its low bits from the byte just received.
                wpage_next     = {addr_reg[`EEPW_ADDR_W-1:8], sh_reg[7:`EEPW_OFS_W]};
                valid_next     = '0;
              end
              default: begin
                buf_we = 1'b1;
                valid_next[addr_reg[`EEPW_OFS_W-1:0]] = 1'b1;
                had_data_next = 1'b1;
                addr_next[`EEPW_OFS_W-1:0] = addr_reg[`EEPW_OFS_W-1:0]
                                             + `EEPW_OFS_W'(1);
              end
            endcase
          end
        end
        eepw_pkg::ST_ACK: begin
          if (scl_fall) begin
            cnt_next = '0;
            if (kind_reg == eepw_pkg::KIND_DEV && rw_reg) begin
              st_next   = eepw_pkg::ST_TX;
              sh_next   = mem[addr_reg];
              oe_next   = ~mem[addr_reg][7];
              addr_next = addr_reg + `EEPW_ADDR_W'(1);
            end else begin
              st_next = eepw_pkg::ST_RX;
              oe_next = 1'b0;
              if (kind_reg == eepw_pkg::KIND_DEV) begin
                kind_next = eepw_pkg::KIND_AHI;
              end else if (kind_reg == eepw_pkg::KIND_AHI) begin
                kind_next = eepw_pkg::KIND_ALO;
              end else begin
                kind_next = eepw_pkg::KIND_DATA;
              end
            end
          end
        end
        eepw_pkg::ST_TX: begin
          if (scl_fall) begin
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == 4'h7) begin
              st_next = eepw_pkg::ST_RACK;
              oe_next = 1'b0;
            end else begin
              sh_next = {sh_reg[6:0], 1'b0};
              oe_next = ~sh_reg[6];
            end
          end
        end
        eepw_pkg::ST_RACK: begin
          if (scl_rise) begin
            rw_next = ~flt_line.sda;
          end else if (scl_fall) begin
            if (rw_reg) begin
              st_next   = eepw_pkg::ST_TX;
              cnt_next  = '0;
              sh_next   = mem[addr_reg];
              oe_next   = ~mem[addr_reg][7];
              addr_next = addr_reg + `EEPW_ADDR_W'(1);
            end else begin
              st_next = eepw_pkg::ST_IDLE;
              rw_next = 1'b1;
            end
          end
        end
        eepw_pkg::ST_IDLE: begin
          oe_next = 1'b0;
        end
        default: begin
          st_next = eepw_pkg::ST_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  // The read counter wraps over the full 13 bits, the write pointer only over
  // its five offset bits, so a write never spills into the next page.
  always_ff @(posedge i_link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      st_reg       <= eepw_pkg::ST_IDLE;
      kind_reg     <= eepw_pkg::KIND_DEV;
      cnt_reg      <= '0;
      sh_reg       <= '0;
      addr_reg     <= '0;
      wpage_reg    <= '0;
      valid_reg    <= '0;
      rw_reg       <= 1'b0;
      oe_reg       <= 1'b0;
      had_data_reg <= 1'b0;
      busy_reg     <= 1'b0;
      req_tgl_reg  <= 1'b0;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      por_cnt_reg  <= '0;
      por_ok_reg   <= 1'b0;
      done1_reg    <= 1'b0;
      done2_reg    <= 1'b0;
      done3_reg    <= 1'b0;
    end else begin
      st_reg       <= st_next;
      kind_reg     <= kind_next;
      cnt_reg      <= cnt_next;
      sh_reg       <= sh_next;
      addr_reg     <= addr_next;
      wpage_reg    <= wpage_next;
      valid_reg    <= valid_next;
      rw_reg       <= rw_next;
      oe_reg       <= oe_next;
      had_data_reg <= had_data_next;
      busy_reg     <= busy_next;
      req_tgl_reg  <= req_tgl_next;
      scl_prev_reg <= flt_line.scl;
      sda_prev_reg <= flt_line.sda;
      por_cnt_reg  <= por_cnt_next;
      por_ok_reg   <= por_ok_next;
      done1_reg    <= done_tgl_reg;
      done2_reg    <= done1_reg;
      done3_reg    <= done2_reg;
    end
  end

  // ========================================================================
  // Page buffer and array; only the buffered (valid) bytes are committed as the timer ends
  always_ff @(posedge i_link_clk) begin
    if (buf_we) begin
      page_buf[addr_reg[`EEPW_OFS_W-1:0]] <= sh_reg;
    end
  end

  // One process owns the array; separate generated processes could not share it.
  always_ff @(posedge i_link_clk) begin
    for (int p = 0; p < `EEPW_PAGE_BYTES; p++) begin
      if (done_evt && valid_reg[p]) begin
        mem[{wpage_reg, `EEPW_OFS_W'(p)}] <= page_buf[p];
      end
    end
  end

  assign o_sda    = 1'b0;
  assign o_sda_oe = oe_reg;

  // ========================================================================
  // Self-timed program cycle in the core domain
  always_comb begin
    run_next      = run_reg;
    tmr_next      = tmr_reg;
    done_tgl_next = done_tgl_reg;
    if (req2_reg ^ req3_reg) begin
      run_next = 1'b1;
      tmr_next = '0;
    end else if (run_reg) begin
      tmr_next = tmr_reg + `EEPW_TIMER_W'(1);
      if (tmr_reg == `EEPW_TIMER_W'(PROG_CYCLES - 1)) begin
        run_next      = 1'b0;
        done_tgl_next = ~done_tgl_reg;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      req1_reg     <= 1'b0;
      req2_reg     <= 1'b0;
      req3_reg     <= 1'b0;
      done_tgl_reg <= 1'b0;
      run_reg      <= 1'b0;
      tmr_reg      <= '0;
    end else begin
      req1_reg     <= req_tgl_reg;
      req2_reg     <= req1_reg;
      req3_reg     <= req2_reg;
      done_tgl_reg <= done_tgl_next;
      run_reg      <= run_next;
      tmr_reg      <= tmr_next;
    end
  end

endmodule : eepw_top

// >>> dv/eepw_props.sv
// Pin-level checker for the serial EEPROM target, bound to its top module.
`timescale 1ns/1ps
module eepw_props (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_link_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic i_chip_select_strap_bit0,
  input wire logic i_chip_select_strap_bit1,
  input wire logic i_chip_select_strap_bit2
);
  // ==========
  // Frame tracking on the raw pins, so it never trusts the design's own filter.
  logic       scl_q;
  logic       sda_q;
  logic       frame_reg;
  logic       first_reg;
  logic       dir_reg;
  logic [3:0] bit_reg;

  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_q     <= 1'b0;
      sda_q     <= 1'b0;
      frame_reg <= 1'b0;
      first_reg <= 1'b0;
      dir_reg   <= 1'b0;
      bit_reg   <= 4'h0;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      if (i_scl && scl_q && sda_q && !i_sda) begin
        frame_reg <= 1'b1;
        first_reg <= 1'b1;
        bit_reg   <= 4'h0;
      end else if (i_scl && scl_q && !sda_q && i_sda) begin
        frame_reg <= 1'b0;
      end else if (i_scl && !scl_q && frame_reg) begin
        bit_reg <= (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
        if (bit_reg == 4'h8) first_reg <= 1'b0;
        if (first_reg && bit_reg == 4'h7) dir_reg <= i_sda;
      end
    end
  end

  sequence s_rx_bit;
    frame_reg && i_scl && !scl_q && bit_reg != 4'h8 && (first_reg || !dir_reg);
  endsequence
  sequence s_ack_slot;
    frame_reg && i_scl && !scl_q && bit_reg == 4'h8 && !first_reg && dir_reg;
  endsequence

  // ==========
  // Assertions
  a_open_drain: assert property (
    @(posedge i_link_clk) o_sda == 1'b0) else $error("data pin value not low");
  a_reset_quiet: assert property (
    @(posedge i_link_clk) !i_rstn |-> !o_sda_oe) else $error("pin driven in reset");
  a_por_quiet: assert property (
    @(posedge i_link_clk) disable iff (!i_rstn) $rose(i_rstn) |-> !o_sda_oe [*8])
    else $error("pin driven right after reset");
  a_oe_scl_low: assert property (
    @(posedge i_link_clk) disable iff (!i_rstn) $changed(o_sda_oe) |-> !i_scl)
    else $error("data changed while clock high");
  a_ack_hold: assert property (
    @(posedge i_link_clk) disable iff (!i_rstn) $rose(o_sda_oe) |-> o_sda_oe [*8])
    else $error("low drive too short");
  a_release_hold: assert property (
    @(posedge i_link_clk) disable iff (!i_rstn) $fell(o_sda_oe) |-> !o_sda_oe [*8])
    else $error("release too short");
  a_idle_quiet: assert property (
    @(posedge i_link_clk) disable iff (!i_rstn) !frame_reg |-> !o_sda_oe)
    else $error("pin driven outside a frame");
  a_rx_listen: assert property (
    @(posedge i_link_clk) disable iff (!i_rstn) s_rx_bit |-> !o_sda_oe)
    else $error("pin driven on a received bit");
  a_tx_release: assert property (
    @(posedge i_link_clk) disable iff (!i_rstn) s_ack_slot |-> !o_sda_oe)
    else $error("pin driven in controller ack slot");
endmodule : eepw_props

bind eepw_top eepw_props u_eepw_props (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_link_clk(i_link_clk), .i_scl(i_scl),
  .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
  .i_chip_select_strap_bit0(i_chip_select_strap_bit0),
  .i_chip_select_strap_bit1(i_chip_select_strap_bit1),
  .i_chip_select_strap_bit2(i_chip_select_strap_bit2));

// >>> dv/eepw_host.sv
// Behavioural two-wire bus controller facing the EEPROM target.
`timescale 1ns/1ps
module eepw_host #(
  parameter int QCYC = 40
) (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // ==========
  // Bus phases; SCL stands high between frames.
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic wq();
    repeat (QCYC) @(negedge i_clk);
  endtask : wq

  // Serves first and repeated starts alike.
  task automatic frame_start();
    o_sda_low = 1'b0;
    wq();
    o_scl = 1'b1;
    wq();
    o_sda_low = 1'b1;
    wq();
    o_scl = 1'b0;
    wq();
  endtask : frame_start

  task automatic frame_stop();
    o_sda_low = 1'b1;
    wq();
    o_scl = 1'b1;
    wq();
    o_sda_low = 1'b0;
    wq();
    wq();
  endtask : frame_stop

  // A one is sent by releasing the line, so the pull-up gives the level.
  task automatic clock_bit(input logic drive, output logic seen);
    o_sda_low = !drive;
    wq();
    o_scl = 1'b1;
    wq();
    seen = i_sda;
    wq();
    o_scl = 1'b0;
    wq();
  endtask : clock_bit

  task automatic put_byte(input logic [7:0] d, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
    clock_bit(1'b1, s);
    acked = !s;
  endtask : put_byte

  task automatic get_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, d[i]);
    clock_bit(!more, s);
  endtask : get_byte
endmodule : eepw_host

// >>> dv/testbench.sv
// Self-checking bench for the serial EEPROM target.
`timescale 1ns/1ps
module testbench;
  // ==========
  // Setup
  localparam logic [3:0] TYPE  = 4'h5; // Arbitrary value, as in the design.
  localparam logic [2:0] STRAP = 3'h5;
  localparam int         PROG  = 2000;
  typedef struct packed {
    logic [7:0] dev;
    logic       ack;
  } eepw_row_t;
  logic      i_clk;
  logic      i_rstn;
  logic      i_link_clk;
  logic      o_sda;
  logic      o_sda_oe;
  logic      scl;
  logic      host_low;
  logic      sda_wire;
  logic      ack;
  int        bad_count;
  int        n_tests;
  eepw_row_t rows [6];

  assign sda_wire = !host_low && (o_sda_oe ? o_sda : 1'b1);

  eepw_top #(.PROG_CYCLES(PROG), .DEVICE_TYPE_CODE(TYPE)) u_eepw_top (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_link_clk(i_link_clk), .i_scl(scl),
    .i_sda(sda_wire), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
    .i_chip_select_strap_bit0(STRAP[0]), .i_chip_select_strap_bit1(STRAP[1]),
    .i_chip_select_strap_bit2(STRAP[2]));
  eepw_host #(.QCYC(40)) u_eepw_host (
    .i_clk(i_clk), .i_sda(sda_wire), .o_scl(scl), .o_sda_low(host_low));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    i_link_clk = 1'b0;
    #3.7;
    forever #6 i_link_clk = ~i_link_clk;
  end

  // ==========
  // Helpers
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  function automatic logic [7:0] dev(input logic rd);
    return {TYPE, STRAP, rd};
  endfunction : dev

  task automatic send(input logic [7:0] d, input logic exp);
    u_eepw_host.put_byte(d, ack);
    check("ack", {7'h0, exp}, {7'h0, ack});
  endtask : send

  task automatic poll(input logic exp);
    u_eepw_host.frame_start();
    send(dev(1'b0), exp);
    u_eepw_host.frame_stop();
  endtask : poll

  task automatic addr(input logic [12:0] a);
    u_eepw_host.frame_start();
    send(dev(1'b0), 1'b1);
    send({3'h0, a[12:8]}, 1'b1);
    send(a[7:0], 1'b1);
  endtask : addr

  // The first poll lands inside the program time, the second after it.
  task automatic write_seq(input logic [12:0] a, input logic [7:0] d[$]);
    addr(a);
    foreach (d[i]) send(d[i], 1'b1);
    u_eepw_host.frame_stop();
    poll(1'b0);
    poll(1'b1);
    $display("write test done");
  endtask : write_seq

  task automatic read_seq(input logic [7:0] e[$]);
    logic [7:0] got;
    u_eepw_host.frame_start();
    send(dev(1'b1), 1'b1);
    foreach (e[i]) begin
      u_eepw_host.get_byte(i < e.size() - 1, got);
      check("data", e[i], got);
    end
    u_eepw_host.frame_stop();
    $display("read test done");
  endtask : read_seq

  // ==========
  // Main sequence
  initial begin
    i_rstn    = 1'b0;
    bad_count = 0;
    n_tests   = 0;
    rows = '{'{dev(1'b0), 1'b1}, '{{TYPE ^ 4'h1, STRAP, 1'b0}, 1'b0},
             '{{TYPE, STRAP ^ 3'h1, 1'b1}, 1'b0}, '{{TYPE, STRAP ^ 3'h2, 1'b0}, 1'b0},
             '{{TYPE, STRAP ^ 3'h4, 1'b1}, 1'b0}, '{dev(1'b0), 1'b1}};
    repeat (8) @(posedge i_clk);
    @(negedge i_clk) i_rstn = 1'b1;
    repeat (10) @(negedge i_clk);
    poll(1'b0);
    repeat (1000) @(negedge i_clk);
    $display("power-on test done");
    foreach (rows[i]) begin
      u_eepw_host.frame_start();
      send(rows[i].dev, rows[i].ack);
      u_eepw_host.frame_stop();
    end
    $display("address word test done");
    write_seq(13'h001f, '{8'h3c, 8'hc3, 8'h96});
    write_seq(13'h001f, '{8'h71});
    read_seq('{8'hc3, 8'h96});
    write_seq(13'h1fff, '{8'he8});
    addr(13'h1fff);
    read_seq('{8'he8, 8'hc3, 8'h96});
    addr(13'h1fff);
    read_seq('{8'he8});
    read_seq('{8'hc3, 8'h96});
    @(negedge i_clk) i_rstn = 1'b0;
    repeat (12) @(negedge i_clk);
    check("oe in reset", 8'h00, {7'h0, o_sda_oe});
    i_rstn = 1'b1;
    poll(1'b0);
    repeat (1000) @(negedge i_clk);
    poll(1'b1);
    $display("mid-run reset test done");
    stop_test();
  end

  // A hang ends the run the same way as the tests do.
  initial begin
    repeat (90000) @(posedge i_clk);
    bad_count++;
    $display("watchdog expired");
    stop_test();
  end
endmodule : testbench
